/* frcct_pkg.sv */
// package: register map, field layouts and types of the capture timer
package frcct_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_IRQ_EN = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_CNT_HI = 4'h2;
   localparam logic [3:0] ADDR_CNT_LO = 4'h3;
   localparam logic [3:0] ADDR_CMP_HI = 4'h4;
   localparam logic [3:0] ADDR_CMP_LO = 4'h5;
   localparam logic [3:0] ADDR_TCR = 4'h6;
   localparam logic [3:0] ADDR_OUT_CTRL = 4'h7;
   localparam logic [3:0] CAP_MASK = 4'h8;
   localparam logic [3:0] CAP_BASE = 4'h8;

   // ------------------------------------------------------------
   // field positions and widths
   // ------------------------------------------------------------
   localparam int FLAG_W = 7;
   localparam int FLG_CAP = 0;
   localparam int FLG_CMP = 4;
   localparam int FLG_OVF = 6;
   localparam int STAT_CLR_BIT = 7;
   localparam int TAP_DIV2 = 0;
   localparam int TAP_DIV8 = 2;
   localparam int TAP_DIV32 = 4;
   localparam int EXT_PIN = 4;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] OUT_CTRL_RST = 8'hE0;
   localparam logic [7:0] OUT_CTRL_FIXED = 8'hE0;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FRCCT_CLK_DIV2,
      FRCCT_CLK_DIV8,
      FRCCT_CLK_DIV32,
      FRCCT_CLK_EXT
   } frcct_clk_t;

   typedef struct packed {
      logic edge_select_a;
      logic edge_select_b;
      logic edge_select_c;
      logic edge_select_d;
      logic buffer_enable_a;
      logic buffer_enable_b;
      frcct_clk_t clock_select;
   } frcct_tcr_t;

   typedef struct packed {
      logic [2:0] fixed_ones;
      logic compare_reg_select;
      logic out_en_a;
      logic out_en_b;
      logic out_level_a;
      logic out_level_b;
   } frcct_out_ctrl_t;
endpackage

/* frcct_timer.sv */
// capture compare timer: counter, two compares, four captures
`timescale 1ns/1ps
// Operation
// R1: counter starts at zero after reset, counts up per tick
// R2: clock select picks clock/2, /8, /32 or external pin
// R3: external clock counts on each rising edge
// R4: external pulses last at least 1.5 system clocks; the pin filter counts a level only once two successive clock samples agree
// R5: on compare match drive output pin to channel level bit
// R6: compare pins are low after reset until first match
// R7: match A clears counter when clear-on-match bit set
// R8: selected capture edge copies counter and sets capture flag
// R9: set capture flag with enable requests interrupt
// R10: buffered capture moves old A or B value into C or D
// R11: buffered C or D edges set flag only, never copy counter
// R12: opposite A and C polarities capture both edges
// R13: capture during upper-byte read of its register waits a clock
// R14: buffered pair upper-byte read also delays the capture
// R15: match pulse comes as counter leaves value, sets compare flag
// R16: overflow flag sets when counter wraps to zero
// R17: low-power modes hold every register at reset value
// R18: seven enabled sources merge onto one interrupt request
// R19: clear beats a simultaneous counter low-byte write
// R20: counter low-byte write beats a simultaneous increment
// R21: upper byte written first into latch, low write loads both
// R22: upper read of counter or capture latches low byte
// R23: compare registers share address, select bit chooses
// R24: compare low-byte write suppresses simultaneous match
// R25: flags clear by writing zero after reading one; set wins
module frcct_timer (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_low_power,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ext_clock,
   input wire logic i_capture_pin_a,
   input wire logic i_capture_pin_b,
   input wire logic i_capture_pin_c,
   input wire logic i_capture_pin_d,
   output logic o_compare_out_pin_a,
   output logic o_compare_out_pin_b,
   output logic o_compare_out_en_a,
   output logic o_compare_out_en_b,
   output logic o_irq
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic rst;
   logic [4:0] pin_raw;
   logic [4:0] sync1_ff, sync2_ff, sync3_ff, pin_lvl_ff, nxt_pin_lvl;
   logic [4:0] rise, fall;
   logic [4:0] presc_ff;
   logic src_lvl, src_prev_ff, tick;
   frcct_pkg::frcct_tcr_t tcr_ff;
   frcct_pkg::frcct_out_ctrl_t oc_ff;
   logic [7:0] ien_ff;
   logic clear_a_ff;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [15:0] cmp_ff [2];
   logic [15:0] cap_ff [4];
   logic [15:0] nxt_cap [4];
   logic [7:0] temp_ff, nxt_temp;
   logic [7:0] rdata_ff, rd_mux;
   logic [6:0] flag_ff, nxt_flag, armed_ff, nxt_armed, set, clr_mask;
   logic [1:0] out_pin_ff, nxt_out_pin, lvl, eq, match, wr_cmp_ch;
   logic [1:0] buf_en;
   logic [3:0] es, trig, blk, rd_hi, want, go, pend_ff, store;
   logic is_cap, rd_cap_hi, cap_hi, clr, ovf_evt;
   logic wr_ien, wr_stat, rd_stat, wr_cnt_lo, wr_cmp_lo, wr_hi;
   logic wr_tcr, wr_oc, rd_cnt_hi;
   logic [1:0] cap_idx;
   logic [15:0] wr_val, cap_a_w;
   logic lvl_a_w;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      return a == b;
   endfunction

   function automatic logic edge_hit(input logic r, input logic f,
                                     input logic s);
      return s ? r : f;
   endfunction

   // R17: low-power hold
   assign rst = i_srst | i_low_power;

   // ------------------------------------------------------------
   // pin synchronisers, a change counts once two stages agree
   // ------------------------------------------------------------
   assign pin_raw = {i_ext_clock, i_capture_pin_d, i_capture_pin_c,
                     i_capture_pin_b, i_capture_pin_a};
   assign nxt_pin_lvl = (sync2_ff & sync3_ff)
                      | (pin_lvl_ff & (sync2_ff | sync3_ff));
   assign rise = nxt_pin_lvl & ~pin_lvl_ff;
   assign fall = ~nxt_pin_lvl & pin_lvl_ff;

   // free running, so a pin held high through reset gives no edge
   always_ff @(posedge i_clock) begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_lvl_ff <= nxt_pin_lvl;
   end

   // ------------------------------------------------------------
   // counter clock
   // ------------------------------------------------------------
   // R2: clock source mux
   assign src_lvl =
      (tcr_ff.clock_select == frcct_pkg::FRCCT_CLK_DIV2) ?
         presc_ff[frcct_pkg::TAP_DIV2] :
      (tcr_ff.clock_select == frcct_pkg::FRCCT_CLK_DIV8) ?
         presc_ff[frcct_pkg::TAP_DIV8] :
      (tcr_ff.clock_select == frcct_pkg::FRCCT_CLK_DIV32) ?
         presc_ff[frcct_pkg::TAP_DIV32] :
         ~pin_lvl_ff[frcct_pkg::EXT_PIN];
   // R3: falling source edge is a tick
   assign tick = src_prev_ff & ~src_lvl;

   always_ff @(posedge i_clock) begin
      if (rst) begin
         presc_ff <= 5'h00;
         src_prev_ff <= 1'b0;
      end else begin
         presc_ff <= presc_ff + 5'h01;
         src_prev_ff <= src_lvl;
      end
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign wr_ien = i_wr & hit(i_addr, frcct_pkg::ADDR_IRQ_EN);
   assign wr_stat = i_wr & hit(i_addr, frcct_pkg::ADDR_STATUS);
   assign rd_stat = i_rd & hit(i_addr, frcct_pkg::ADDR_STATUS);
   assign wr_cnt_lo = i_wr & hit(i_addr, frcct_pkg::ADDR_CNT_LO);
   assign wr_cmp_lo = i_wr & hit(i_addr, frcct_pkg::ADDR_CMP_LO);
   assign wr_hi = i_wr & (hit(i_addr, frcct_pkg::ADDR_CNT_HI)
                        | hit(i_addr, frcct_pkg::ADDR_CMP_HI));
   assign wr_tcr = i_wr & hit(i_addr, frcct_pkg::ADDR_TCR);
   assign wr_oc = i_wr & hit(i_addr, frcct_pkg::ADDR_OUT_CTRL);
   assign rd_cnt_hi = i_rd & hit(i_addr, frcct_pkg::ADDR_CNT_HI);
   assign is_cap = hit(i_addr & frcct_pkg::CAP_MASK, frcct_pkg::CAP_BASE);
   assign cap_idx = i_addr[2:1];
   assign cap_hi = ~i_addr[0];
   assign rd_cap_hi = i_rd & is_cap & cap_hi;
   assign wr_val = {temp_ff, i_wdata};

   // R21: upper byte parks in latch
   // R22: upper read latches low byte
   always_comb begin
      nxt_temp = temp_ff;
      if (wr_hi) begin
         nxt_temp = i_wdata;
      end else if (rd_cnt_hi) begin
         nxt_temp = cnt_ff[7:0];
      end else if (rd_cap_hi) begin
         nxt_temp = cap_ff[cap_idx][7:0];
      end
   end

   // R23: shared compare address
   always_comb begin
      case (i_addr)
         frcct_pkg::ADDR_IRQ_EN: rd_mux = ien_ff;
         frcct_pkg::ADDR_STATUS: rd_mux = {clear_a_ff, flag_ff};
         frcct_pkg::ADDR_CNT_HI: rd_mux = cnt_ff[15:8];
         frcct_pkg::ADDR_CNT_LO: rd_mux = temp_ff;
         frcct_pkg::ADDR_CMP_HI:
            rd_mux = cmp_ff[oc_ff.compare_reg_select][15:8];
         frcct_pkg::ADDR_CMP_LO:
            rd_mux = cmp_ff[oc_ff.compare_reg_select][7:0];
         frcct_pkg::ADDR_TCR: rd_mux = tcr_ff;
         frcct_pkg::ADDR_OUT_CTRL: rd_mux = oc_ff;
         default: rd_mux = cap_hi ? cap_ff[cap_idx][15:8] : temp_ff;
      endcase
   end

   // ------------------------------------------------------------
   // capture triggers
   // ------------------------------------------------------------
   assign buf_en = {tcr_ff.buffer_enable_b, tcr_ff.buffer_enable_a};
   assign es = {tcr_ff.edge_select_d, tcr_ff.edge_select_c,
                tcr_ff.edge_select_b, tcr_ff.edge_select_a};

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // R12: both polarities in buffered mode
         trig[i] = edge_hit(rise[i], fall[i], es[i])
                 | (buf_en[i] & edge_hit(rise[i], fall[i], es[i + 2]));
         // R11: buffered c/d edges from a/b pin
         trig[i + 2] = buf_en[i] ?
            edge_hit(rise[i], fall[i], es[i + 2]) :
            edge_hit(rise[i + 2], fall[i + 2], es[i + 2]);
      end
      for (int i = 0; i < 4; i++) begin
         rd_hi[i] = rd_cap_hi & (cap_idx == 2'(i));
      end
      for (int i = 0; i < 4; i++) begin
         // R13: own upper read blocks
         // R14: pair upper read blocks
         blk[i] = rd_hi[i] | (buf_en[i % 2] & rd_hi[i ^ 2]);
      end
   end

   assign want = trig | pend_ff;
   assign go = want & ~blk;
   assign store = {~buf_en[1], ~buf_en[0], 2'b11};

   always_comb begin
      nxt_cap = cap_ff;
      for (int i = 0; i < 4; i++) begin
         // R8: copy counter on capture
         if (go[i] & store[i]) begin
            nxt_cap[i] = cnt_ff;
         end
      end
      for (int i = 0; i < 2; i++) begin
         // R10: old value moves to buffer
         if (go[i] & buf_en[i]) begin
            nxt_cap[i + 2] = cap_ff[i];
         end
      end
   end

   // ------------------------------------------------------------
   // compare and counter
   // ------------------------------------------------------------
   assign eq = {cnt_ff == cmp_ff[1], cnt_ff == cmp_ff[0]};
   assign wr_cmp_ch = {2{wr_cmp_lo}}
      & {oc_ff.compare_reg_select, ~oc_ff.compare_reg_select};
   // R15: match as counter leaves value
   // R24: compare write suppresses match
   assign match = {2{tick}} & eq & ~wr_cmp_ch;
   // R7: clear on match a
   assign clr = match[0] & clear_a_ff;
   // R16: wrap detect
   assign ovf_evt = tick & (cnt_ff == frcct_pkg::CNT_MAX) & ~clr & ~wr_cnt_lo;
   // R19: clear before write
   // R20: write before increment
   // R1: count up per tick
   assign nxt_cnt = clr ? frcct_pkg::CNT_RST :
                    wr_cnt_lo ? wr_val :
                    tick ? cnt_ff + 16'h0001 : cnt_ff;

   assign lvl = {oc_ff.out_level_b, oc_ff.out_level_a};
   // R5: pin takes level on match
   assign nxt_out_pin = (match & lvl) | (~match & out_pin_ff);

   // ------------------------------------------------------------
   // flags and interrupt
   // ------------------------------------------------------------
   assign set = {ovf_evt, match, go};
   assign clr_mask = wr_stat ? (armed_ff & ~i_wdata[frcct_pkg::FLAG_W-1:0])
                             : 7'h00;
   // R25: set wins over clear
   assign nxt_flag = set | (flag_ff & ~clr_mask);
   assign nxt_armed = rd_stat ? flag_ff : (armed_ff & ~clr_mask);
   // R9: enabled flag requests
   // R18: seven sources, one request
   assign o_irq = |(flag_ff & ien_ff[frcct_pkg::FLAG_W-1:0]);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (rst) begin
         cnt_ff <= frcct_pkg::CNT_RST;
         cmp_ff[0] <= frcct_pkg::CMP_RST;
         cmp_ff[1] <= frcct_pkg::CMP_RST;
         temp_ff <= frcct_pkg::BYTE_RST;
         rdata_ff <= frcct_pkg::BYTE_RST;
         // R6: pins low after reset
         out_pin_ff <= 2'b00;
      end else begin
         cnt_ff <= nxt_cnt;
         if (wr_cmp_ch[0]) begin
            cmp_ff[0] <= wr_val;
         end
         if (wr_cmp_ch[1]) begin
            cmp_ff[1] <= wr_val;
         end
         temp_ff <= nxt_temp;
         rdata_ff <= i_rd ? rd_mux : frcct_pkg::BYTE_RST;
         out_pin_ff <= nxt_out_pin;
      end
   end

   always_ff @(posedge i_clock) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            cap_ff[i] <= frcct_pkg::CAP_RST;
         end
         pend_ff <= 4'h0;
         flag_ff <= 7'h00;
         armed_ff <= 7'h00;
      end else begin
         cap_ff <= nxt_cap;
         pend_ff <= want & blk;
         flag_ff <= nxt_flag;
         armed_ff <= nxt_armed;
      end
   end

   always_ff @(posedge i_clock) begin
      if (rst) begin
         ien_ff <= frcct_pkg::BYTE_RST;
         clear_a_ff <= 1'b0;
         tcr_ff <= frcct_pkg::frcct_tcr_t'(frcct_pkg::BYTE_RST);
         oc_ff <= frcct_pkg::frcct_out_ctrl_t'(frcct_pkg::OUT_CTRL_RST);
      end else begin
         if (wr_ien) begin
            ien_ff <= {1'b0, i_wdata[frcct_pkg::FLAG_W-1:0]};
         end
         if (wr_stat) begin
            clear_a_ff <= i_wdata[frcct_pkg::STAT_CLR_BIT];
         end
         if (wr_tcr) begin
            tcr_ff <= frcct_pkg::frcct_tcr_t'(i_wdata);
         end
         if (wr_oc) begin
            oc_ff <= frcct_pkg::frcct_out_ctrl_t'(
               i_wdata | frcct_pkg::OUT_CTRL_FIXED);
         end
      end
   end

   assign o_rdata = rdata_ff;
   assign o_compare_out_pin_a = out_pin_ff[0];
   assign o_compare_out_pin_b = out_pin_ff[1];
   assign o_compare_out_en_a = oc_ff.out_en_a;
   assign o_compare_out_en_b = oc_ff.out_en_b;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   assign cap_a_w = cap_ff[0];
   assign lvl_a_w = oc_ff.out_level_a;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_srst);

   cnt_clear_a: assert property (clr |=> cnt_ff == 16'h0000) // R7 R19
      else $error("counter not cleared on match a");
   cnt_inc_a: assert property ( // R1
      tick && !clr && !wr_cnt_lo && !i_low_power
      |=> cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("counter did not advance on tick");
   wr_wins_a: assert property ( // R20
      wr_cnt_lo && !clr && !i_low_power |=> cnt_ff == $past(wr_val))
      else $error("counter write lost");
   out_level_a: assert property ( // R5
      match[0] && !i_low_power
      |=> o_compare_out_pin_a == $past(lvl_a_w))
      else $error("compare pin a wrong level");
   cmp_flag_a: assert property ( // R15
      match[0] && !i_low_power |=> flag_ff[frcct_pkg::FLG_CMP])
      else $error("compare flag a not set");
   wr_block_a: assert property ( // R24
      wr_cmp_ch[0] && !i_low_power
      |=> o_compare_out_pin_a == $past(o_compare_out_pin_a))
      else $error("match during compare write");
   wrap_flag_a: assert property ( // R16
      ovf_evt && !i_low_power
      |=> flag_ff[frcct_pkg::FLG_OVF] && cnt_ff == 16'h0000)
      else $error("wrap not flagged");
   cap_store_a: assert property ( // R8
      go[0] && !i_low_power
      |=> cap_ff[0] == $past(cnt_ff) && flag_ff[frcct_pkg::FLG_CAP])
      else $error("capture a not stored");
   buf_move_a: assert property ( // R10
      go[0] && buf_en[0] && !i_low_power |=> cap_ff[2] == $past(cap_a_w))
      else $error("buffer c not loaded from a");
   no_c_copy_a: assert property ( // R11
      go[2] && buf_en[0] && !go[0] && !i_low_power |=> $stable(cap_ff[2]))
      else $error("buffer c loaded from counter");
   cap_delay_a: assert property ( // R13
      trig[0] && blk[0] && !i_low_power ##1 !blk[0] |-> go[0])
      else $error("delayed capture a lost");
   pair_hold_a: assert property ( // R14
      buf_en[0] && rd_hi[2] && !i_low_power |=> $stable(cap_ff[2]))
      else $error("buffer c changed during upper read");
   set_wins_a: assert property ( // R25
      go[0] && wr_stat && !i_low_power |=> flag_ff[frcct_pkg::FLG_CAP])
      else $error("capture flag clear beat set");
   irq_req_a: assert property ( // R9
      go[0] && ien_ff[frcct_pkg::FLG_CAP] && !wr_ien && !i_low_power
      |=> o_irq)
      else $error("capture a did not request");
   lp_hold_a: assert property ( // R17
      i_low_power |=> cnt_ff == 16'h0000 && flag_ff == 7'h00
      && !o_compare_out_pin_a)
      else $error("low power did not hold reset");

   buf_cap_c: cover property (go[0] && buf_en[0]);
   clr_cap_c: cover property (clr);
   wrap_cap_c: cover property (ovf_evt);
   delay_cap_c: cover property (trig[0] && blk[0]);
endmodule

/* frcct_cpu_model.sv */
// cpu bus master model driving the capture timer register port
`timescale 1ns/1ps
module frcct_cpu_model (
   input wire logic i_clock,
   output logic [3:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   // ------------------------------------------------------------
   // single byte cycles
   // ------------------------------------------------------------
   initial begin
      o_addr = 4'h0;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge i_clock);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clock);
      o_rd <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // sixteen bit pairs
   // ------------------------------------------------------------
   // upper byte first
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 4'h1, v[7:0]);
   endtask

   task automatic rd16(input logic [3:0] a);
      rd(a);
      rd(a + 4'h1);
   endtask
endmodule

/* tb.sv */
// self-checking testbench for the capture compare timer
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic low_power = 1'b0;
   logic ext_clock = 1'b0;
   logic cap_a = 1'b0;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic wr, rd, rd_d, pin_a, pin_b, en_a, en_b, irq;
   logic [15:0] notes[$];
   logic [15:0] note, v;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int i;

   always #2 clk = ~clk;

   frcct_cpu_model frcct_cpu_model_inst (.i_clock(clk), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

   frcct_timer frcct_timer_inst (.i_clock(clk), .i_srst(srst),
      .i_low_power(low_power), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_clock(ext_clock),
      .i_capture_pin_a(cap_a), .i_capture_pin_b(cap_a),
      .i_capture_pin_c(cap_a), .i_capture_pin_d(cap_a),
      .o_compare_out_pin_a(pin_a), .o_compare_out_pin_b(pin_b),
      .o_compare_out_en_a(en_a), .o_compare_out_en_b(en_b), .o_irq(irq));

   // ------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   always @(negedge clk) begin
      if (rd_d === 1'b1) begin
         note = notes.pop_front();
         chk("rdata", {8'h00, note[7:0]}, {8'h00, rdata & note[15:8]});
      end
   end

   // ------------------------------------------------------------
   // stimulus helpers
   // ------------------------------------------------------------
   task automatic rd8(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m);
      notes.push_back({m, e});
      frcct_cpu_model_inst.rd(a);
   endtask

   task automatic rd16(input logic [3:0] a, input logic [15:0] e);
      notes.push_back({8'hFF, e[15:8]});
      notes.push_back({8'hFF, e[7:0]});
      frcct_cpu_model_inst.rd16(a);
   endtask

   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      frcct_cpu_model_inst.wr(a, d);
   endtask

   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      frcct_cpu_model_inst.wr16(a, d);
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_clock <= 1'b1;
         repeat (4) @(posedge clk);
         ext_clock <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask

   task automatic clr_flags();
      rd8(frcct_pkg::ADDR_STATUS, 8'h00, 8'h80);
      wr8(frcct_pkg::ADDR_STATUS, 8'h00);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      v = 16'($urandom(2));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      chk("pin_a", 16'h0000, {15'h0000, pin_a});
      rd8(frcct_pkg::ADDR_OUT_CTRL, 8'hE0, 8'hFF);
      rd8(frcct_pkg::ADDR_TCR, 8'h00, 8'hFF);
      rd8(frcct_pkg::ADDR_IRQ_EN, 8'h00, 8'hFF);
      $display("reset test done");
      wr8(frcct_pkg::ADDR_TCR, 8'h03);
      for (i = 0; i < 4; i++) begin
         v = 16'($urandom);
         wr16(frcct_pkg::ADDR_CNT_HI, v);
         rd16(frcct_pkg::ADDR_CNT_HI, v);
      end
      wr16(frcct_pkg::ADDR_CNT_HI, 16'h1234);
      pulse(3);
      rd16(frcct_pkg::ADDR_CNT_HI, 16'h1237);
      clr_flags();
      wr16(frcct_pkg::ADDR_CNT_HI, 16'hFFFF);
      pulse(1);
      rd8(frcct_pkg::ADDR_STATUS, 8'h40, 8'h40);
      rd16(frcct_pkg::ADDR_CNT_HI, 16'h0000);
      $display("count test done");
      wr8(frcct_pkg::ADDR_OUT_CTRL, 8'h1A);
      wr16(frcct_pkg::ADDR_CMP_HI, 16'h0100);
      wr8(frcct_pkg::ADDR_OUT_CTRL, 8'h0A);
      wr16(frcct_pkg::ADDR_CMP_HI, 16'h0005);
      rd16(frcct_pkg::ADDR_CMP_HI, 16'h0005);
      wr8(frcct_pkg::ADDR_OUT_CTRL, 8'h1A);
      rd16(frcct_pkg::ADDR_CMP_HI, 16'h0100);
      wr8(frcct_pkg::ADDR_OUT_CTRL, 8'h0A);
      clr_flags();
      wr16(frcct_pkg::ADDR_CNT_HI, 16'h0004);
      pulse(1);
      chk("pin_a", 16'h0000, {15'h0000, pin_a});
      rd8(frcct_pkg::ADDR_STATUS, 8'h00, 8'h10);
      pulse(1);
      chk("pin_a", 16'h0001, {15'h0000, pin_a});
      chk("en_a", 16'h0001, {15'h0000, en_a});
      chk("en_b", 16'h0000, {15'h0000, en_b});
      chk("pin_b", 16'h0000, {15'h0000, pin_b});
      rd8(frcct_pkg::ADDR_STATUS, 8'h10, 8'h10);
      rd16(frcct_pkg::ADDR_CNT_HI, 16'h0006);
      clr_flags();
      wr8(frcct_pkg::ADDR_STATUS, 8'h80);
      wr16(frcct_pkg::ADDR_CNT_HI, 16'h0004);
      pulse(2);
      rd16(frcct_pkg::ADDR_CNT_HI, 16'h0000);
      rd8(frcct_pkg::ADDR_STATUS, 8'h90, 8'hD0);
      wr8(frcct_pkg::ADDR_STATUS, 8'h00);
      $display("compare test done");
      wr8(frcct_pkg::ADDR_TCR, 8'h83);
      wr16(frcct_pkg::ADDR_CNT_HI, 16'h0200);
      clr_flags();
      wr8(frcct_pkg::ADDR_IRQ_EN, 8'h01);
      @(posedge clk);
      cap_a <= 1'b1;
      repeat (8) @(posedge clk);
      rd16(frcct_pkg::CAP_BASE, 16'h0200);
      rd8(frcct_pkg::ADDR_STATUS, 8'h01, 8'h01);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr8(frcct_pkg::ADDR_IRQ_EN, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq", 16'h0000, {15'h0000, irq});
      $display("capture test done");
      wr8(frcct_pkg::ADDR_TCR, 8'h8B);
      wr16(frcct_pkg::ADDR_CNT_HI, 16'h0300);
      @(posedge clk);
      cap_a <= 1'b0;
      repeat (8) @(posedge clk);
      rd16(frcct_pkg::CAP_BASE, 16'h0300);
      rd16(frcct_pkg::CAP_BASE + 4'h4, 16'h0200);
      rd8(frcct_pkg::ADDR_STATUS, 8'h04, 8'h04);
      rd16(frcct_pkg::CAP_BASE + 4'h2, 16'h0300);
      rd16(frcct_pkg::CAP_BASE + 4'h6, 16'h0300);
      wr16(frcct_pkg::ADDR_CNT_HI, 16'h0301);
      @(posedge clk);
      cap_a <= 1'b1;
      repeat (8) @(posedge clk);
      rd16(frcct_pkg::CAP_BASE, 16'h0301);
      rd16(frcct_pkg::CAP_BASE + 4'h4, 16'h0300);
      $display("buffer test done");
      @(posedge clk);
      low_power <= 1'b1;
      @(posedge clk);
      low_power <= 1'b0;
      rd8(frcct_pkg::ADDR_TCR, 8'h00, 8'hFF);
      rd8(frcct_pkg::ADDR_OUT_CTRL, 8'hE0, 8'hFF);
      rd16(frcct_pkg::CAP_BASE, 16'h0000);
      chk("pin_a", 16'h0000, {15'h0000, pin_a});
      $display("low power test done");
      for (i = 0; i < 3; i++) begin
         wr8(frcct_pkg::ADDR_TCR, 8'(i));
         wr16(frcct_pkg::ADDR_CNT_HI, 16'h0000);
         repeat ((21 << (2 * i)) - 1) @(posedge clk);
         rd8(frcct_pkg::ADDR_CNT_HI, 8'h00, 8'hFF);
         rd8(frcct_pkg::ADDR_CNT_LO, 8'h0A, 8'hFE);
      end
      $display("prescaler test done");
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule
